// ### fsc_regs.svh
// register offsets, field positions, reset values, command codes and timing
`ifndef FSC_REGS_SVH
`define FSC_REGS_SVH

// serial command codes
`define FSC_OP_WRITE_REGS 8'h01
`define FSC_OP_READ_SR2 8'h07
`define FSC_OP_READ_ANY 8'h65
`define FSC_OP_WRITE_ANY 8'h71

// register addresses used by the generic read and write commands
`define FSC_ADDR_SR2 24'h000001
`define FSC_ADDR_NONVOLATILE_CONFIG_ONE 24'h000002

// second status register fields
`define FSC_SR2_ERASE_DONE 2
`define FSC_SR2_ERASE_SUSP 1
`define FSC_SR2_PROG_SUSP 0
`define FSC_SR2_RESET 8'h00

// configuration register fields
`define FSC_CR1_PROT_START 5
`define FSC_CR1_BP_VOLATILE 3
`define FSC_CR1_PARAM_LOC 2
`define FSC_CR1_QUAD 1
`define FSC_CR1_FREEZE 0
`define FSC_CR1_RESET 8'h00

// protection bits in the first byte of the write-registers command
`define FSC_SR1_BP_HI 4
`define FSC_SR1_BP_LO 2
`define FSC_BP_RESET 3'h0
`define FSC_BP_ALL 3'h7

// non-volatile write time
`define FSC_CLK_NS 10
`define FSC_NV_WRITE_NS 160
`define FSC_NV_WRITE_CYC (`FSC_NV_WRITE_NS / `FSC_CLK_NS)

`endif

// ### fsc_pkg.sv
// types shared by the status and configuration register logic
package fsc_pkg;

    typedef logic [15:0] fsc_count_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_OPC = 3'h1,
        ST_ADDR = 3'h2,
        ST_READ = 3'h3,
        ST_WRR1 = 3'h4,
        ST_WRR2 = 3'h5,
        ST_WDATA = 3'h6,
        ST_IGNORE = 3'h7
    } fsc_state_e;

    typedef struct packed {
        logic [1:0] sck_s;
        logic [1:0] cs_n_s;
        logic [1:0] si_s;
        logic sck_last;
        logic cs_n_last;
        logic [2:0] bits;
        logic [7:0] rx;
        logic [7:0] tx;
        logic rx_valid;
        logic fstart;
        logic fend;
    } fsc_shift_s;

    typedef struct packed {
        fsc_state_e st;
        fsc_state_e after_addr;
        logic [1:0] cnt;
        logic [23:0] addr;
        logic [7:0] tx;
        logic tx_en;
        logic sr1_got;
        logic cr1_got;
        logic wdata_got;
        logic [7:0] sr1_byte;
        logic [7:0] cr1_byte;
        logic [7:0] wdata;
        logic [7:0] sr2;
        logic [7:0] nonvolatile_config_one;
        logic [2:0] nv_bp;
        logic [2:0] vol_bp;
        logic quad_vol;
        logic freeze_vol;
        fsc_count_t busy;
    } fsc_core_s;

endpackage

// ### fsc_byte_if.sv
// byte-level link between the serial shifter and the command engine
interface fsc_byte_if;
    logic frame_start;
    logic frame_end;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic tx_en;

    modport shifter(
        output frame_start, frame_end, rx_valid, rx_byte,
        input tx_byte, tx_en
    );
    modport engine(
        input frame_start, frame_end, rx_valid, rx_byte,
        output tx_byte, tx_en
    );
endinterface

// ### fsc_spi_shifter.sv
// serial pin shifter: synchronises pins, assembles and sends bytes (mode 0)
module fsc_spi_shifter (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // serial pins
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    output logic so_out,
    output logic so_oe_out,
    // byte side
    fsc_byte_if.shifter bus
);

    fsc_pkg::fsc_shift_s s_q;
    fsc_pkg::fsc_shift_s s_d;

    // pins are slow against mclk: the serial clock must stay in each
    // level for at least four mclk cycles
    always_comb begin
        s_d = s_q;
        s_d.rx_valid = 1'b0;
        s_d.fstart = 1'b0;
        s_d.fend = 1'b0;
        s_d.sck_s = {s_q.sck_s[0], sck_in};
        s_d.cs_n_s = {s_q.cs_n_s[0], cs_n_in};
        s_d.si_s = {s_q.si_s[0], si_in};
        s_d.sck_last = s_q.sck_s[1];
        s_d.cs_n_last = s_q.cs_n_s[1];
        if (s_q.cs_n_s[1]) begin
            s_d.bits = 3'h0;
            if (!s_q.cs_n_last) begin
                s_d.fend = 1'b1;
            end
        end else begin
            if (s_q.cs_n_last) begin
                s_d.fstart = 1'b1;
                s_d.bits = 3'h0;
            end else if (s_q.sck_s[1] && !s_q.sck_last) begin
                s_d.rx = {s_q.rx[6:0], s_q.si_s[1]};
                s_d.bits = s_q.bits + 3'h1;
                if (s_q.bits == 3'h7) begin
                    s_d.rx_valid = 1'b1;
                end
            end else if (!s_q.sck_s[1] && s_q.sck_last) begin
                // a new byte is taken only on a byte boundary
                if (s_q.bits == 3'h0) begin
                    s_d.tx = bus.tx_byte;
                end else begin
                    s_d.tx = {s_q.tx[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            s_q <= '{sck_s: 2'h0, cs_n_s: 2'h3, si_s: 2'h0, sck_last: 1'b0,
                     cs_n_last: 1'b1, bits: 3'h0, rx: 8'h00, tx: 8'h00,
                     rx_valid: 1'b0, fstart: 1'b0, fend: 1'b0};
        end else if (ce_in) begin
            s_q <= s_d;
        end
    end

    assign bus.frame_start = s_q.fstart;
    assign bus.frame_end = s_q.fend;
    assign bus.rx_valid = s_q.rx_valid;
    assign bus.rx_byte = s_q.rx;
    assign so_out = s_q.tx[7];
    assign so_oe_out = ~s_q.cs_n_s[1] & bus.tx_en;

endmodule

// ### fsc_status_config.sv
// second status register and non-volatile configuration register engine
`include "fsc_regs.svh"

// Functional notes
// - second status is read-only, volatile; bits 7..3 read as zero.
// - command 07h and generic read 65h both return second status.
// - bit 2 shows whether the queried sector finished its last erase.
// - erase result is invalid, and reads zero, while anything is suspended.
// - bit 1 follows erase-suspend mode; writes never change it.
// - bit 0 follows program-suspend mode; writes never change it.
// - config changes by 24-cycle write-registers or by generic write.
// - config bit 5 picks protection start: 0 top, 1 bottom.
// - one-time bits 5, 3, 2 ship 0; once 1 they stay, silently.
// - bit 3 zero: write-registers writes nv protect bits, slow write.
// - setting bit 3 programs nv protect 111; volatile bits reload from it.
// - bit 3 one: write-registers updates volatile protect bits only, fast.
// - bit 2 places parameter block: 1 top, 0 bottom.
// - uniform sectors make the parameter-location bit have no effect.
// - protection start and parameter location are set independently.
// - bit 1 is quad-width default, written by both write commands.
// - programming nv quad-command mode also sets the quad-width default.
// - while volatile quad-command mode is on, quad default cannot clear.
// - bit 0 is read-only freeze default, loaded into volatile freeze.
// - volatile copies of bits 5, 3, 2 always mirror the nv bits.
module fsc_status_config #(
    parameter int NV_WRITE_CYCLES = `FSC_NV_WRITE_CYC
) (
    // clock, reset, enable
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // serial pins
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    output logic so_out,
    output logic so_oe_out,
    // device state from the array controller
    input wire logic erase_done_result_in,
    input wire logic erase_suspended_in,
    input wire logic program_suspended_in,
    input wire logic quad_command_mode_in,
    input wire logic quad_width_default_program_in,
    input wire logic uniform_sectors_in,
    input wire logic soft_reset_in,
    // register views
    output logic [7:0] suspend_erase_status_out,
    output logic [7:0] nonvolatile_config_one_out,
    output logic [7:0] volatile_config_one_out,
    output logic [2:0] block_protect_bits_out,
    output logic [2:0] nonvolatile_protect_bits_out,
    // decoded options
    output logic protect_start_select_out,
    output logic param_block_location_out,
    output logic erase_result_valid_out,
    output logic nv_write_busy_out
);

    fsc_byte_if link ();

    fsc_spi_shifter u_shifter (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .sck_in(sck_in),
        .cs_n_in(cs_n_in),
        .si_in(si_in),
        .so_out(so_out),
        .so_oe_out(so_oe_out),
        .bus(link.shifter)
    );

    fsc_pkg::fsc_core_s c_q;
    fsc_pkg::fsc_core_s c_d;

    // value returned by a generic read at a given address
    function automatic logic [7:0] reg_read(
        input logic [23:0] addr,
        input logic [7:0] sr2,
        input logic [7:0] cr1
    );
        logic [7:0] r;
        r = 8'h00;
        // generic read also reaches second status
        if (addr == `FSC_ADDR_SR2) begin
            r = sr2;
        end else if (addr == `FSC_ADDR_NONVOLATILE_CONFIG_ONE) begin
            r = cr1;
        end
        return r;
    endfunction

    // new configuration value after a user write
    function automatic logic [7:0] cr1_merge(
        input logic [7:0] old,
        input logic [7:0] d,
        input logic quad_command_mode
    );
        logic [7:0] r;
        r = 8'h00;
        // one-time bits only ever go from 0 to 1
        r[`FSC_CR1_PROT_START] = old[`FSC_CR1_PROT_START]
                               | d[`FSC_CR1_PROT_START];
        r[`FSC_CR1_BP_VOLATILE] = old[`FSC_CR1_BP_VOLATILE]
                                | d[`FSC_CR1_BP_VOLATILE];
        r[`FSC_CR1_PARAM_LOC] = old[`FSC_CR1_PARAM_LOC]
                              | d[`FSC_CR1_PARAM_LOC];
        r[`FSC_CR1_QUAD] = d[`FSC_CR1_QUAD];
        // no clearing while quad-command mode is on
        if (quad_command_mode) begin
            r[`FSC_CR1_QUAD] = old[`FSC_CR1_QUAD] | d[`FSC_CR1_QUAD];
        end
        r[`FSC_CR1_FREEZE] = old[`FSC_CR1_FREEZE];
        return r;
    endfunction

    logic suspended;
    logic busy;
    logic cr1_wr;
    logic [7:0] cr1_wdata;
    logic bp_wr;
    logic [7:0] cr1_new;

    assign suspended = erase_suspended_in | program_suspended_in;
    assign busy = (c_q.busy != 16'h0000);

    always_comb begin
        c_d = c_q;
        cr1_wr = 1'b0;
        cr1_wdata = c_q.cr1_byte;
        bp_wr = 1'b0;
        cr1_new = c_q.nonvolatile_config_one;

        c_d.sr2 = `FSC_SR2_RESET;
        // erase result from the preceding query
        c_d.sr2[`FSC_SR2_ERASE_DONE] = erase_done_result_in & ~suspended;
        c_d.sr2[`FSC_SR2_ERASE_SUSP] = erase_suspended_in;
        c_d.sr2[`FSC_SR2_PROG_SUSP] = program_suspended_in;

        if (busy) begin
            c_d.busy = c_q.busy - 16'h0001;
        end

        if (link.frame_start) begin
            c_d.st = fsc_pkg::ST_OPC;
            c_d.tx_en = 1'b0;
            c_d.sr1_got = 1'b0;
            c_d.cr1_got = 1'b0;
            c_d.wdata_got = 1'b0;
            c_d.cnt = 2'h0;
        end else if (link.frame_end) begin
            c_d.st = fsc_pkg::ST_IDLE;
            c_d.tx_en = 1'b0;
            // writes that arrive during a slow write are dropped; reads still run
            if (!busy) begin
                // 24-cycle write-registers reaches the config byte
                cr1_wr = c_q.cr1_got;
                bp_wr = c_q.sr1_got;
                // only the config address accepts generic writes
                if (c_q.wdata_got && c_q.addr == `FSC_ADDR_NONVOLATILE_CONFIG_ONE) begin
                    cr1_wr = 1'b1;
                    cr1_wdata = c_q.wdata;
                end
            end
        end else if (link.rx_valid) begin
            case (c_q.st)
                fsc_pkg::ST_OPC: begin
                    case (link.rx_byte)
                        `FSC_OP_READ_SR2: begin
                            c_d.st = fsc_pkg::ST_READ;
                            c_d.addr = `FSC_ADDR_SR2;
                            c_d.tx = c_q.sr2;
                            c_d.tx_en = 1'b1;
                        end
                        `FSC_OP_READ_ANY: begin
                            c_d.st = fsc_pkg::ST_ADDR;
                            c_d.after_addr = fsc_pkg::ST_READ;
                        end
                        `FSC_OP_WRITE_ANY: begin
                            c_d.st = fsc_pkg::ST_ADDR;
                            c_d.after_addr = fsc_pkg::ST_WDATA;
                        end
                        `FSC_OP_WRITE_REGS: begin
                            c_d.st = fsc_pkg::ST_WRR1;
                        end
                        default: begin
                            c_d.st = fsc_pkg::ST_IGNORE;
                        end
                    endcase
                end
                fsc_pkg::ST_ADDR: begin
                    c_d.addr = {c_q.addr[15:0], link.rx_byte};
                    c_d.cnt = c_q.cnt + 2'h1;
                    if (c_q.cnt == 2'h2) begin
                        c_d.st = c_q.after_addr;
                        if (c_q.after_addr == fsc_pkg::ST_READ) begin
                            c_d.tx = reg_read({c_q.addr[15:0], link.rx_byte},
                                              c_q.sr2, c_q.nonvolatile_config_one);
                            c_d.tx_en = 1'b1;
                        end
                    end
                end
                fsc_pkg::ST_READ: begin
                    // repeated reads return the live value
                    c_d.tx = reg_read(c_q.addr, c_q.sr2, c_q.nonvolatile_config_one);
                end
                fsc_pkg::ST_WRR1: begin
                    c_d.sr1_byte = link.rx_byte;
                    c_d.sr1_got = 1'b1;
                    c_d.st = fsc_pkg::ST_WRR2;
                end
                fsc_pkg::ST_WRR2: begin
                    c_d.cr1_byte = link.rx_byte;
                    c_d.cr1_got = 1'b1;
                    c_d.st = fsc_pkg::ST_IGNORE;
                end
                fsc_pkg::ST_WDATA: begin
                    c_d.wdata = link.rx_byte;
                    c_d.wdata_got = 1'b1;
                    c_d.st = fsc_pkg::ST_IGNORE;
                end
                default: begin
                    c_d.st = c_q.st;
                end
            endcase
        end

        if (bp_wr) begin
            if (c_q.nonvolatile_config_one[`FSC_CR1_BP_VOLATILE]) begin
                // volatile bits only, no slow write
                c_d.vol_bp = c_q.sr1_byte[`FSC_SR1_BP_HI:`FSC_SR1_BP_LO];
            end else begin
                // non-volatile bits take the slow write time
                c_d.nv_bp = c_q.sr1_byte[`FSC_SR1_BP_HI:`FSC_SR1_BP_LO];
                c_d.vol_bp = c_q.sr1_byte[`FSC_SR1_BP_HI:`FSC_SR1_BP_LO];
                c_d.busy = fsc_pkg::fsc_count_t'(NV_WRITE_CYCLES);
            end
        end

        if (cr1_wr) begin
            // each one-time bit merges on its own
            cr1_new = cr1_merge(c_q.nonvolatile_config_one, cr1_wdata, quad_command_mode_in);
            c_d.nonvolatile_config_one = cr1_new;
            c_d.busy = fsc_pkg::fsc_count_t'(NV_WRITE_CYCLES);
            // turning protect bits volatile programs nv ones to 111
            if (cr1_new[`FSC_CR1_BP_VOLATILE]
                && !c_q.nonvolatile_config_one[`FSC_CR1_BP_VOLATILE]) begin
                c_d.nv_bp = `FSC_BP_ALL;
            end
        end

        // nv quad-command mode forces the quad default on
        if (quad_width_default_program_in) begin
            c_d.nonvolatile_config_one[`FSC_CR1_QUAD] = 1'b1;
        end

        // command or hardware reset reloads volatile copies
        if (soft_reset_in) begin
            c_d.vol_bp = c_d.nv_bp;
            c_d.quad_vol = c_d.nonvolatile_config_one[`FSC_CR1_QUAD];
            c_d.freeze_vol = c_d.nonvolatile_config_one[`FSC_CR1_FREEZE];
            c_d.st = fsc_pkg::ST_IDLE;
            c_d.tx_en = 1'b0;
        end
    end

    // rst_in stands for power-on: non-volatile bits take shipped values
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            c_q <= '{st: fsc_pkg::ST_IDLE, after_addr: fsc_pkg::ST_IDLE,
                     cnt: 2'h0, addr: 24'h000000, tx: 8'h00, tx_en: 1'b0,
                     sr1_got: 1'b0, cr1_got: 1'b0, wdata_got: 1'b0,
                     sr1_byte: 8'h00, cr1_byte: 8'h00, wdata: 8'h00,
                     sr2: `FSC_SR2_RESET, nonvolatile_config_one: `FSC_CR1_RESET,
                     nv_bp: `FSC_BP_RESET, vol_bp: `FSC_BP_RESET,
                     quad_vol: 1'b0, freeze_vol: 1'b0, busy: 16'h0000};
        end else if (ce_in) begin
            c_q <= c_d;
        end
    end

    assign link.tx_byte = c_q.tx;
    assign link.tx_en = c_q.tx_en;

    assign suspend_erase_status_out = c_q.sr2;
    assign nonvolatile_config_one_out = c_q.nonvolatile_config_one;
    // bits 5, 3, 2 are wired straight from the nv register
    assign volatile_config_one_out = {2'h0,
                                      c_q.nonvolatile_config_one[`FSC_CR1_PROT_START], 1'b0,
                                      c_q.nonvolatile_config_one[`FSC_CR1_BP_VOLATILE],
                                      c_q.nonvolatile_config_one[`FSC_CR1_PARAM_LOC],
                                      c_q.quad_vol, c_q.freeze_vol};
    assign block_protect_bits_out = c_q.vol_bp;
    assign nonvolatile_protect_bits_out = c_q.nv_bp;
    // 0 protects from the top, 1 from the bottom
    assign protect_start_select_out = c_q.nonvolatile_config_one[`FSC_CR1_PROT_START];
    assign param_block_location_out = c_q.nonvolatile_config_one[`FSC_CR1_PARAM_LOC]
                                     & ~uniform_sectors_in;
    assign erase_result_valid_out = ~suspended;
    assign nv_write_busy_out = busy;

endmodule

// ### fsc_status_config_sva.sv
// assertion checker for the status and configuration register block
module fsc_status_config_sva #(
    parameter int NV_WRITE_CYCLES = 16
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // device state
    input wire logic erase_done_result_in,
    input wire logic erase_suspended_in,
    input wire logic program_suspended_in,
    input wire logic quad_command_mode_in,
    input wire logic quad_width_default_program_in,
    input wire logic uniform_sectors_in,
    // register views
    input wire logic [7:0] suspend_erase_status_out,
    input wire logic [7:0] nonvolatile_config_one_out,
    input wire logic [7:0] volatile_config_one_out,
    input wire logic [2:0] nonvolatile_protect_bits_out,
    input wire logic protect_start_select_out,
    input wire logic param_block_location_out,
    input wire logic erase_result_valid_out,
    input wire logic nv_write_busy_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] busy_run_q;
    logic [7:0] busy_run_d;

    // length of the current busy run, so its end can be judged
    always_comb begin
        busy_run_d = nv_write_busy_out ? busy_run_q + 8'h01 : 8'h00;
        if (rst_in) begin
            busy_run_d = 8'h00;
        end
    end
    always_ff @(posedge mclk_in) begin
        busy_run_q <= busy_run_d;
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    sr2_reserved_zero_a: assert property (
        suspend_erase_status_out[7:3] == 5'h00) else $error("sr2 reserved");
    suspend_follow_a: assert property (!$past(rst_in) |->
        suspend_erase_status_out[1:0] ==
        $past({erase_suspended_in, program_suspended_in}))
        else $error("suspend bits wrong");
    erase_result_bit_a: assert property (!$past(rst_in) |->
        suspend_erase_status_out[2] == $past(erase_done_result_in &&
        !erase_suspended_in && !program_suspended_in))
        else $error("erase result wrong");
    result_valid_a: assert property (erase_result_valid_out ==
        !(erase_suspended_in || program_suspended_in)) else $error("valid");
    param_place_a: assert property (param_block_location_out ==
        (nonvolatile_config_one_out[2] && !uniform_sectors_in))
        else $error("param location wrong");
    volatile_mirror_a: assert property (volatile_config_one_out[7:2] ==
        (nonvolatile_config_one_out[7:2] & 6'h0b)) else $error("mirror");
    config_reserved_a: assert property (
        (nonvolatile_config_one_out & 8'hd1) == 8'h00) else $error("rsvd");
    otp_bits_stay_a: assert property (!$past(rst_in) |->
        ($past(nonvolatile_config_one_out) & ~nonvolatile_config_one_out
        & 8'h2c) == 8'h00) else $error("one-time bit cleared");
    prot_start_a: assert property ($stable(nonvolatile_config_one_out[5])
        |-> protect_start_select_out == nonvolatile_config_one_out[5])
        else $error("protect start wrong");
    nv_protect_all_a: assert property (
        $rose(nonvolatile_config_one_out[3]) |->
        ##[0:2] nonvolatile_protect_bits_out == 3'h7) else $error("nv bp");
    quad_held_a: assert property (!$past(rst_in) &&
        $past(quad_command_mode_in) && $past(nonvolatile_config_one_out[1])
        |-> nonvolatile_config_one_out[1]) else $error("quad cleared");
    quad_program_a: assert property (quad_width_default_program_in |=>
        nonvolatile_config_one_out[1]) else $error("quad not set");
    busy_length_a: assert property ($fell(nv_write_busy_out) |->
        busy_run_q >= NV_WRITE_CYCLES && busy_run_q <= NV_WRITE_CYCLES + 1)
        else $error("busy length wrong");

    cover property ($rose(nv_write_busy_out));
    cover property ($rose(nonvolatile_config_one_out[3]));
    cover property (suspend_erase_status_out == 8'h04);
endmodule

// ### fsc_host_model.sv
// serial host model: mode 0 frames, clock rests low between frames
module fsc_host_model (
    // clock
    input wire logic mclk_in,
    // serial pins
    output logic sck_out,
    output logic cs_n_out,
    output logic si_out,
    input wire logic so_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        si_out = 1'b0;
    end

    // opcode then data bits msb first, sent left-aligned from tx
    task automatic xfer(input logic [47:0] tx, input int n,
                        output logic [47:0] rx);
        rx = '0;
        @(negedge mclk_in);
        cs_n_out = 1'b0;
        for (int i = 0; i < n; i++) begin
            si_out = tx[47 - i];
            repeat (6) @(negedge mclk_in);
            sck_out = 1'b1;
            rx = {rx[46:0], so_in};
            repeat (6) @(negedge mclk_in);
            sck_out = 1'b0;
        end
        repeat (6) @(negedge mclk_in);
        cs_n_out = 1'b1;
        // an idle line must not go on looking like the last bit
        si_out = ~si_out;
        repeat (6) @(negedge mclk_in);
    endtask
endmodule

// ### tb.sv
// testbench: register traffic over the serial link with expected values
`include "fsc_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
$display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NVC = 20;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic erase_done = 1'b0;
    logic erase_susp = 1'b0;
    logic prog_susp = 1'b0;
    logic qmode = 1'b0;
    logic qprog = 1'b0;
    logic uniform = 1'b0;
    logic soft_rst = 1'b0;
    logic sck, cs_n, si, so, oe, valid, busy, pstart, ploc;
    logic oe_seen = 1'b0;
    logic [7:0] sr2, cr, vcr, d;
    logic [2:0] bp_vol, nonvolatile_protect_bits;
    logic [47:0] r;

    initial begin
        forever #5 mclk_in = ~mclk_in;
    end

    fsc_host_model host (.mclk_in(mclk_in), .sck_out(sck), .cs_n_out(cs_n),
        .si_out(si), .so_in(so));

    fsc_status_config #(.NV_WRITE_CYCLES(NVC)) dut (
        .mclk_in(mclk_in), .rst_in(rst_in), .ce_in(1'b1),
        .sck_in(sck), .cs_n_in(cs_n), .si_in(si), .so_out(so),
        .so_oe_out(oe), .erase_done_result_in(erase_done),
        .erase_suspended_in(erase_susp), .program_suspended_in(prog_susp),
        .quad_command_mode_in(qmode), .quad_width_default_program_in(qprog),
        .uniform_sectors_in(uniform), .soft_reset_in(soft_rst),
        .suspend_erase_status_out(sr2), .nonvolatile_config_one_out(cr),
        .volatile_config_one_out(vcr), .block_protect_bits_out(bp_vol),
        .nonvolatile_protect_bits_out(nonvolatile_protect_bits),
        .protect_start_select_out(pstart), .param_block_location_out(ploc),
        .erase_result_valid_out(valid), .nv_write_busy_out(busy));

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // writes landing while busy are dropped, so always wait it out
    task automatic idle();
        int k = 0;
        while (busy !== 1'b0 && k < 200) begin
            @(negedge mclk_in);
            k++;
        end
        `CHK(busy, 1'b0)
    endtask

    task automatic rd(input logic [23:0] a, input logic ded);
        if (ded) begin
            host.xfer({`FSC_OP_READ_SR2, 40'h0}, 24, r);
            `CHK(r[7:0], r[15:8])
            d = r[15:8];
        end else begin
            host.xfer({`FSC_OP_READ_ANY, a, 16'h0}, 40, r);
            d = r[7:0];
        end
    endtask

    task automatic wr(input logic [47:0] t, input int n);
        host.xfer(t, n, r);
        idle();
    endtask

    always @(posedge mclk_in) begin
        cyc++;
        oe_seen <= oe_seen | (oe === 1'b1);
        if (cyc == 40000) begin
            error_cnt++;
            print_verdict();
        end
    end

    initial begin
        repeat (20) @(negedge mclk_in);
        rst_in = 1'b0;
        repeat (3) @(negedge mclk_in);
        `CHK(cr, `FSC_CR1_RESET)
        `CHK(sr2, `FSC_SR2_RESET)
        `CHK(oe_seen, 1'b0)
        rd(24'h000010, 1'b0);
        `CHK(d, 8'h00)
        `CHK(oe_seen, 1'b1)
        `CHK(oe, 1'b0)
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            {erase_done, erase_susp, prog_susp} = i[2:0];
            rd(`FSC_ADDR_SR2, i[0]);
            `CHK(d, {5'h00, i[2] & ~i[1] & ~i[0], i[1:0]})
            `CHK(valid, ~(i[1] | i[0]))
        end
        wr({`FSC_OP_WRITE_ANY, `FSC_ADDR_SR2, 8'hff, 8'h00}, 40);
        rd(`FSC_ADDR_SR2, 1'b0);
        `CHK(d, 8'h03)
        {erase_done, erase_susp, prog_susp} = 3'h0;
        $display("test status done");
        host.xfer({`FSC_OP_WRITE_REGS, 8'h08, 8'h02, 24'h0}, 24, r);
        `CHK(busy, 1'b1)
        idle();
        `CHK(nonvolatile_protect_bits, 3'h2)
        `CHK(bp_vol, 3'h2)
        rd(`FSC_ADDR_NONVOLATILE_CONFIG_ONE, 1'b0);
        `CHK(d, 8'h02)
        wr({`FSC_OP_WRITE_REGS, 8'h0c, 32'h0}, 16);
        `CHK(nonvolatile_protect_bits, 3'h3)
        `CHK(cr, 8'h02)
        qmode = 1'b1;
        wr({`FSC_OP_WRITE_ANY, `FSC_ADDR_NONVOLATILE_CONFIG_ONE, 8'h00, 8'h00}, 40);
        `CHK(cr, 8'h02)
        qmode = 1'b0;
        $display("test protect done");
        wr({`FSC_OP_WRITE_ANY, `FSC_ADDR_NONVOLATILE_CONFIG_ONE, 8'h20, 8'h00}, 40);
        `CHK(cr, 8'h20)
        `CHK(pstart, 1'b1)
        `CHK(ploc, 1'b0)
        wr({`FSC_OP_WRITE_ANY, `FSC_ADDR_NONVOLATILE_CONFIG_ONE, 8'hff, 8'h00}, 40);
        `CHK(cr, 8'h2e)
        `CHK(ploc, 1'b1)
        `CHK(nonvolatile_protect_bits, 3'h7)
        `CHK(vcr[7:2], 6'h0b)
        uniform = 1'b1;
        @(negedge mclk_in);
        `CHK(ploc, 1'b0)
        uniform = 1'b0;
        wr({`FSC_OP_WRITE_REGS, 8'h04, 8'h2e, 24'h0}, 24);
        `CHK(bp_vol, 3'h1)
        `CHK(nonvolatile_protect_bits, 3'h7)
        soft_rst = 1'b1;
        @(negedge mclk_in);
        soft_rst = 1'b0;
        @(negedge mclk_in);
        `CHK(bp_vol, 3'h7)
        `CHK(vcr, 8'h2e)
        wr({`FSC_OP_WRITE_ANY, `FSC_ADDR_NONVOLATILE_CONFIG_ONE, 8'h00, 8'h00}, 40);
        `CHK(cr, 8'h2c)
        qprog = 1'b1;
        @(negedge mclk_in);
        qprog = 1'b0;
        @(negedge mclk_in);
        `CHK(cr, 8'h2e)
        $display("test config done");
        print_verdict();
    end
endmodule

bind fsc_status_config fsc_status_config_sva #(
    .NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk (
    .mclk_in(mclk_in), .rst_in(rst_in),
    .erase_done_result_in(erase_done_result_in),
    .erase_suspended_in(erase_suspended_in),
    .program_suspended_in(program_suspended_in),
    .quad_command_mode_in(quad_command_mode_in),
    .quad_width_default_program_in(quad_width_default_program_in),
    .uniform_sectors_in(uniform_sectors_in),
    .suspend_erase_status_out(suspend_erase_status_out),
    .nonvolatile_config_one_out(nonvolatile_config_one_out),
    .volatile_config_one_out(volatile_config_one_out),
    .nonvolatile_protect_bits_out(nonvolatile_protect_bits_out),
    .protect_start_select_out(protect_start_select_out),
    .param_block_location_out(param_block_location_out),
    .erase_result_valid_out(erase_result_valid_out),
    .nv_write_busy_out(nv_write_busy_out));
